/* hdl/ebw_pkg.sv */
// package for the external bus window configuration block
// assumes a single 250 MHz clock and an apb register port in front of it
package ebw_pkg;

    // ************************************************************
    // register map, word index; byte address is four times index
    // ************************************************************
    localparam logic [15:0] REG_WIN0_IDX = 16'hFF0C; // bus_window0_control
    localparam logic [15:0] REG_WIN1_IDX = 16'hFF14; // bus_window1_control
    localparam logic [15:0] REG_WIN2_IDX = 16'hFF16; // bus_window2_control
    localparam logic [15:0] REG_WIN3_IDX = 16'hFF18; // bus_window3_control
    localparam logic [15:0] REG_WIN4_IDX = 16'hFF1A; // bus_window4_control
    localparam logic [15:0] REG_STAT_IDX = 16'hFF1E; // engine status, read only
    localparam int ADDR_W = 18; // apb address width covering the map

    // ************************************************************
    // field positions and reset values
    // ************************************************************
    localparam int POS_WAIT = 0; // cycle_wait_count, four bits
    localparam int POS_DELAY = 4; // command_delay_bit
    localparam int POS_TRI = 5; // tristate_wait_bit
    localparam int POS_BUS_TYPE_FIELD = 6; // bus_type_field, two bits
    localparam int POS_LEN = 9; // strobe_lengthen_bit
    localparam int POS_ACT = 10; // window_bus_enable
    localparam int POS_HANDSHAKE_INPUT_ENABLE = 12; // handshake_input_enable
    localparam int POS_HANDSHAKE_POLARITY = 13; // handshake_polarity
    localparam int POS_CSR = 14; // select_on_read
    localparam int POS_CSW = 15; // select_on_write
    localparam logic [15:0] WIN_RESET = 16'h0000; // reset value of every window
    localparam logic [15:0] WIN_WMASK = 16'hF6FF; // bits 11 and 8 are reserved

    // ************************************************************
    // timing: one clock_half_period at the core clock
    // ************************************************************
    localparam int CLK_PERIOD_PS = 4000; // 250 MHz
    localparam int HALF_PERIOD_PS = 2000; // clock_half_period
    localparam int HALF_PERIOD_CYC = (HALF_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [3:0] MAX_WAITS = 4'hF; // waits for a zero wait field

    // ************************************************************
    // types
    // ************************************************************
    typedef struct packed {
        logic csw; // select_on_write
        logic csr; // select_on_read
        logic handshake_polarity; // handshake_polarity
        logic handshake_input_enable; // handshake_input_enable
        logic rsv11;
        logic act; // window_bus_enable
        logic len; // strobe_lengthen_bit
        logic rsv8;
        logic [1:0] bus_type_field; // bus_type_field
        logic tri_n; // tristate_wait_bit
        logic dly_n; // command_delay_bit
        logic [3:0] wait_cnt; // cycle_wait_count
    } ebw_cfg_t;

    typedef struct packed {
        logic ale; // address latch strobe, high active
        logic rd_n; // read command
        logic wr_n; // write command
        logic cs_n; // window chip select
    } ebw_pins_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ALE = 3'h1,
        ST_ALE_LONG = 3'h3,
        ST_DELAY = 3'h2,
        ST_CMD = 3'h6,
        ST_TRI = 3'h7,
        ST_DONE = 3'h5
    } ebw_state_t;

endpackage : ebw_pkg

/* hdl/ebw_strap.sv */
// captures the boot straps once, on the first edge after reset release
// assumes ea and boot port pins are steady around the reset release
`timescale 1ns/1ps
module ebw_strap
    import ebw_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // strap pins
    input wire logic external_access_pin,
    input wire logic [1:0] boot_bus_type_field,
    // captured values
    output logic strap_load,
    output logic strap_ea,
    output logic [1:0] strap_bus_type_field
);
    logic done; // straps already taken

    // take the pins at the first edge after release, never under reset
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            done <= 1'b0;
            strap_load <= 1'b0;
            strap_ea <= 1'b0;
            strap_bus_type_field <= 2'h0;
        end else begin
            strap_load <= ~done;
            done <= 1'b1;
            if (!done) begin
                strap_ea <= external_access_pin;
                strap_bus_type_field <= boot_bus_type_field;
            end
        end
    end
endmodule : ebw_strap

/* hdl/ebw_sel.sv */
// picks and holds the configuration of the window that an access hits
// assumes the window index is below the window count
`timescale 1ns/1ps
module ebw_sel
    import ebw_pkg::*;
#(
    parameter int NUM_WIN = 5
)
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // all window configurations
    input wire ebw_cfg_t cfg_all [NUM_WIN],
    // selection
    input wire logic load,
    input wire logic [2:0] win,
    // held configuration
    output ebw_cfg_t cfg_cur
);
    // held for the whole cycle so a register write cannot disturb it
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cfg_cur <= ebw_cfg_t'(WIN_RESET);
        end else if (load) begin
            cfg_cur <= cfg_all[win];
        end
    end
endmodule : ebw_sel

/* hdl/ebw_top.sv */
// external bus window configuration: five window control registers on
// apb and the strobe sequencer that runs one external cycle per request
// assumes requests come from a cpu side that already decoded the window
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
module ebw_top
    import ebw_pkg::*;
#(
    parameter int NUM_WIN = 5
)
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // boot straps
    input wire logic external_access_pin,
    input wire logic [7:0] boot_config_port,
    // cpu side access request
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [2:0] req_window,
    output logic req_ready,
    output logic req_done,
    output logic req_err,
    // external bus
    input wire logic ready_pin,
    output ebw_pins_t bus_pins,
    output logic bus_16bit,
    output logic bus_mux
);

    // ************************************************************
    // declarations
    // ************************************************************
    ebw_cfg_t win_cfg [NUM_WIN]; // window control registers
    ebw_cfg_t cfg_cur; // configuration of the running cycle
    ebw_state_t state; // sequencer state
    ebw_state_t next_state; // sequencer state to come
    logic [3:0] wait_left; // memory waits still to run
    logic cyc_write; // running cycle is a write
    logic accept; // request taken this edge
    logic strap_load; // one pulse after reset release
    logic strap_ea; // captured external access level
    logic [1:0] strap_bus_type_field; // captured bus type straps
    logic apb_setup; // setup phase of a transfer
    logic apb_wr; // write takes effect
    logic [2:0] apb_win; // decoded window of the address
    logic apb_hit_win; // address names a window register
    logic apb_hit_stat; // address names the status register
    logic rdy_hit; // ready pin shows the ending level
    logic wait_over; // command phase may close
    logic [3:0] win_dec; // window decode of the apb address
    logic boot_done; // straps have been applied to window zero
    ebw_cfg_t cfg_nxt; // configuration that the pins follow next
    logic wr_nxt; // direction that the pins follow next

    // ************************************************************
    // helpers
    // ************************************************************
    // word index to window number, shared by read and write decode
    function automatic logic [3:0] win_of(input logic [ADDR_W-1:0] a);
        logic [15:0] idx;
        idx = 16'(a[ADDR_W-1:2]);
        case (idx)
            REG_WIN0_IDX: win_of = 4'h8;
            REG_WIN1_IDX: win_of = 4'h9;
            REG_WIN2_IDX: win_of = 4'hA;
            REG_WIN3_IDX: win_of = 4'hB;
            REG_WIN4_IDX: win_of = 4'hC;
            default: win_of = 4'h0;
        endcase
    endfunction : win_of

    // ************************************************************
    // submodules
    // ************************************************************
    ebw_strap u_strap (
        .clk(clk),
        .nrst(nrst),
        .external_access_pin(external_access_pin),
        .boot_bus_type_field(boot_config_port[7:6]),
        .strap_load(strap_load),
        .strap_ea(strap_ea),
        .strap_bus_type_field(strap_bus_type_field)
    );

    ebw_sel #(
        .NUM_WIN(NUM_WIN)
    ) u_sel (
        .clk(clk),
        .nrst(nrst),
        .cfg_all(win_cfg),
        .load(accept),
        .win(req_window),
        .cfg_cur(cfg_cur)
    );

    // ************************************************************
    // apb decode
    // ************************************************************
    // bit 3 of the decode says a window register was named
    assign win_dec = win_of(paddr);
    assign apb_hit_win = win_dec[3];
    assign apb_win = win_dec[2:0];
    assign apb_hit_stat = (16'(paddr[ADDR_W-1:2]) == REG_STAT_IDX) && (paddr[1:0] == 2'h0);
    assign apb_setup = psel & ~penable;
    assign apb_wr = psel & penable & pready & pwrite & ~pslverr;

    // answer is prepared in setup, so every transfer has no wait state
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pready <= 1'b0;
        end else begin
            pready <= apb_setup;
        end
    end

    // unaligned or unmapped addresses, and writes to status, are errors
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pslverr <= 1'b0;
        end else if (apb_setup) begin
            pslverr <= ~((apb_hit_win && paddr[1:0] == 2'h0) || (apb_hit_stat && !pwrite));
        end else begin
            pslverr <= 1'b0;
        end
    end

    // read data sit in the low half, upper bits read as zero
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prdata <= 32'h0000_0000;
        end else if (apb_setup && !pwrite) begin
            if (apb_hit_win && paddr[1:0] == 2'h0) begin
                prdata <= {16'h0000, 16'(win_cfg[apb_win])};
            end else if (apb_hit_stat) begin
                // status shows the sequencer and the cycle in flight
                prdata <= {24'h00_0000, cyc_write, wait_left, 3'(state)};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // ************************************************************
    // window control registers
    // ************************************************************
    // window zero is reloaded from the straps once after reset
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            win_cfg[0] <= ebw_cfg_t'(WIN_RESET);
        end else if (strap_load) begin
            if (strap_ea) begin
                win_cfg[0] <= ebw_cfg_t'(WIN_RESET);
            end else begin
                win_cfg[0] <= ebw_cfg_t'(WIN_RESET);
                win_cfg[0].act <= 1'b1;
                win_cfg[0].len <= 1'b1;
                win_cfg[0].bus_type_field <= strap_bus_type_field;
            end
        end else if (apb_wr && apb_win == 3'h0) begin
            win_cfg[0] <= ebw_cfg_t'(pwdata[15:0] & WIN_WMASK);
        end
    end

    // the other windows are plain read/write registers
    generate
        for (genvar w = 1; w < NUM_WIN; w++) begin : g_win
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    win_cfg[w] <= ebw_cfg_t'(WIN_RESET);
                end else if (apb_wr && apb_win == 3'(w)) begin
                    win_cfg[w] <= ebw_cfg_t'(pwdata[15:0] & WIN_WMASK);
                end
            end
        end
    endgenerate

    // ************************************************************
    // request acceptance
    // ************************************************************
    // the window index is not checked; any valid request is taken while ready
    assign accept = req_valid & req_ready;

    // the taken request's own window drives the pins from the first strobe on,
    // otherwise the edge of the take would still show the previous window
    assign cfg_nxt = accept ? win_cfg[req_window] : cfg_cur;
    assign wr_nxt = accept ? req_write : cyc_write;

    // set once the straps reached window zero; holds requests off until then
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            boot_done <= 1'b0;
        end else if (strap_load) begin
            boot_done <= 1'b1;
        end
    end

    // ready only while idle and after the strap cycle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            req_ready <= 1'b0;
        end else begin
            req_ready <= (next_state == ST_IDLE) && !accept && !strap_load && boot_done;
        end
    end

    // direction of the running cycle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cyc_write <= 1'b0;
        end else if (accept) begin
            cyc_write <= req_write;
        end
    end

    // ************************************************************
    // sequencer
    // ************************************************************
    // the ready pin ends a cycle at the level the polarity bit names
    assign rdy_hit = (ready_pin == cfg_cur.handshake_polarity);
    // either the counted waits or the handshake closes the command
    assign wait_over = cfg_cur.handshake_input_enable ? rdy_hit : (wait_left == 4'h0);

    // next state; window chosen at accept is already held in cfg_cur
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (accept) begin
                    next_state = ST_ALE;
                end
            end
            ST_ALE: begin
                if (!cfg_cur.act) begin
                    next_state = ST_DONE;
                end else if (cfg_cur.len) begin
                    next_state = ST_ALE_LONG;
                end else if (!cfg_cur.dly_n) begin
                    next_state = ST_DELAY;
                end else begin
                    next_state = ST_CMD;
                end
            end
            ST_ALE_LONG: begin
                next_state = cfg_cur.dly_n ? ST_CMD : ST_DELAY;
            end
            ST_DELAY: begin
                next_state = ST_CMD;
            end
            ST_CMD: begin
                if (wait_over) begin
                    next_state = cfg_cur.tri_n ? ST_DONE : ST_TRI;
                end
            end
            ST_TRI: begin
                next_state = ST_DONE;
            end
            ST_DONE: begin
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // wait counter loads on entry to the command phase
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wait_left <= 4'h0;
        end else if (next_state == ST_CMD && state != ST_CMD) begin
            wait_left <= MAX_WAITS - cfg_cur.wait_cnt;
        end else if (state == ST_CMD && wait_left != 4'h0) begin
            wait_left <= wait_left - 4'h1;
        end
    end

    // ************************************************************
    // pins
    // ************************************************************
    // strobes follow next_state so they change with the state register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            bus_pins <= '{ale: 1'b0, rd_n: 1'b1, wr_n: 1'b1, cs_n: 1'b1};
        end else begin
            bus_pins.ale <= ((next_state == ST_ALE) || (next_state == ST_ALE_LONG))
                && cfg_nxt.act;
            bus_pins.rd_n <= !((next_state == ST_CMD) && !cyc_write);
            bus_pins.wr_n <= !((next_state == ST_CMD) && cyc_write);
            if (next_state == ST_CMD) begin
                bus_pins.cs_n <= 1'b0;
            end else if (next_state == ST_IDLE || next_state == ST_DONE
                || next_state == ST_TRI || !cfg_nxt.act) begin
                // select ends with the command and stays off through the tristate time
                bus_pins.cs_n <= 1'b1;
            end else if (wr_nxt) begin
                bus_pins.cs_n <= cfg_nxt.csw;
            end else begin
                bus_pins.cs_n <= cfg_nxt.csr;
            end
        end
    end

    // width and multiplexing of the current cycle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            bus_16bit <= 1'b0;
            bus_mux <= 1'b0;
        end else begin
            bus_16bit <= cfg_nxt.bus_type_field[1];
            bus_mux <= cfg_nxt.bus_type_field[0];
        end
    end

    // ************************************************************
    // completion
    // ************************************************************
    // a disabled window finishes at once and flags the refusal
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            req_done <= 1'b0;
            req_err <= 1'b0;
        end else begin
            req_done <= (next_state == ST_DONE);
            req_err <= (next_state == ST_DONE) && !cfg_cur.act;
        end
    end

endmodule : ebw_top

/* tb/ebw_periph.sv */
// far-side model: a peripheral that answers the ready handshake
// assumes the bench sets polarity and answer delay before each cycle
`timescale 1ns/1ps
module ebw_periph
    import ebw_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // bus from the device
    input wire ebw_pins_t bus_pins,
    // answer settings
    input wire logic pol,
    input wire logic [2:0] dly,
    // handshake back to the device
    output logic ready_pin
);
    logic [4:0] cnt; // command cycles seen so far

    // count how long the command has been active; idle clears it
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt <= 5'h00;
        end else if (!bus_pins.rd_n || !bus_pins.wr_n) begin
            cnt <= cnt + 5'h01;
        end else begin
            cnt <= 5'h00;
        end
    end

    // inactive level outside a command, so a stale answer cannot end a cycle
    assign ready_pin = (cnt >= 5'(dly)) ? pol : ~pol;
endmodule : ebw_periph

/* tb/ebw_top_sva.sv */
// checker for the window block, bound to the top module's ports
// assumes one clock domain and the async active-low reset
`timescale 1ns/1ps
module ebw_top_sva
    import ebw_pkg::*;
#(
    parameter int NUM_WIN = 5
)
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // apb handshake
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // request side
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic req_done,
    input wire logic req_err,
    // external bus
    input wire ebw_pins_t bus_pins
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    // ************************************************************
    // properties
    // ************************************************************
    apb_answer_a: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    apb_err_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    take_strobe_a: assert property ($rose(bus_pins.ale) |-> $past(req_valid && req_ready))
        else $error("strobe without a taken request");
    ale_cmd_a: assert property (bus_pins.ale |-> bus_pins.rd_n && bus_pins.wr_n)
        else $error("command overlaps address strobe");
    one_cmd_a: assert property (bus_pins.rd_n || bus_pins.wr_n)
        else $error("read and write both active");
    cs_cmd_a: assert property (!bus_pins.rd_n || !bus_pins.wr_n |-> !bus_pins.cs_n)
        else $error("command without chip select");
    err_quiet_a: assert property (req_err |-> req_done && $past(bus_pins.cs_n)
        && $past(bus_pins.cs_n, 2) && !$past(bus_pins.ale))
        else $error("disabled window drove strobes");
    take_done_a: assert property (req_valid && req_ready |-> ##[2:30] req_done)
        else $error("cycle did not finish");
    idle_pins_a: assert property (req_ready |-> bus_pins.cs_n && bus_pins.rd_n
        && bus_pins.wr_n && !bus_pins.ale)
        else $error("strobes active while idle");
endmodule : ebw_top_sva

bind ebw_top ebw_top_sva #(.NUM_WIN(NUM_WIN)) u_ebw_top_sva (
    .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pready(pready),
    .pslverr(pslverr), .req_valid(req_valid), .req_ready(req_ready),
    .req_done(req_done), .req_err(req_err), .bus_pins(bus_pins)
);

/* tb/ebw_top_tb.sv */
// self-checking bench: apb register traffic, straps and external cycles
// assumes the far-side model answers the ready handshake
`timescale 1ns/1ps
module ebw_top_tb
    import ebw_pkg::*;
;
    logic clk, nrst, psel, penable, pwrite, pready, pslverr, pol;
    logic external_access_pin, req_valid, req_write, req_ready, req_done, req_err;
    logic ready_pin, bus_16bit, bus_mux, rerr;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [7:0] boot_config_port;
    logic [2:0] req_window, dly;
    logic [1:0] bt;
    ebw_pins_t bus_pins;
    ebw_cfg_t cfg [5]; // expected contents of each window
    logic [15:0] widx [5] = '{REG_WIN0_IDX, REG_WIN1_IDX, REG_WIN2_IDX, REG_WIN3_IDX,
        REG_WIN4_IDX};
    logic [15:0] corner [5] = '{16'h0000, 16'h0400, 16'hF63F, 16'h363F, 16'h0680};
    int mismatches, num_checks, seed;

    ebw_top u_ebw_top (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .external_access_pin(external_access_pin),
        .boot_config_port(boot_config_port), .req_valid(req_valid), .req_write(req_write),
        .req_window(req_window), .req_ready(req_ready), .req_done(req_done),
        .req_err(req_err), .ready_pin(ready_pin), .bus_pins(bus_pins),
        .bus_16bit(bus_16bit), .bus_mux(bus_mux));
    ebw_periph u_ebw_periph (.clk(clk), .nrst(nrst), .bus_pins(bus_pins), .pol(pol),
        .dly(dly), .ready_pin(ready_pin));

    // ************************************************************
    // helpers
    // ************************************************************
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task finish_test();
        if (mismatches == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : finish_test

    // one apb transfer; the request is held until pready is sampled high
    task apb(input logic wr, input logic [15:0] idx, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= {idx, 2'b00}; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb

    // board holds the straps steady through reset, then inverts the boot port
    task do_reset(input logic ea, input logic [1:0] b);
        @(posedge clk);
        nrst <= 1'b0; external_access_pin <= ea; boot_config_port <= {b, 6'($urandom)};
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        boot_config_port <= ~boot_config_port;
    endtask : do_reset

    // one external cycle; phases are counted at the falling edge
    task do_acc(input int w, input logic wr);
        ebw_cfg_t c;
        int n, na, ng, nc, ncs, bad;
        logic sc;
        c = cfg[w]; na = 0; ng = 0; nc = 0; ncs = 0; bad = 0; sc = 0; n = 0;
        pol <= c.handshake_polarity;
        dly <= 3'(2 + $urandom % 3);
        do @(negedge clk); while (req_ready !== 1'b1);
        @(posedge clk);
        req_valid <= 1'b1; req_write <= wr; req_window <= 3'(w);
        @(posedge clk);
        req_valid <= 1'b0;
        n = 0;
        do begin
            @(negedge clk);
            n++;
            if (bus_pins.ale === 1'b1) na++;
            else if ((wr ? bus_pins.wr_n : bus_pins.rd_n) === 1'b0) begin
                nc++;
                sc = 1;
            end else if (na > 0 && !sc) ng++;
            if (bus_pins.cs_n === 1'b0) ncs++;
            if ((wr ? bus_pins.rd_n : bus_pins.wr_n) === 1'b0) bad++;
        end while (req_done !== 1'b1 && n < 60);
        if (!c.act) begin
            chk(n, 2);
            chk(req_err, 1);
            chk(na + ncs + nc, 0);
        end else begin
            chk(req_err, 0);
            chk(na, 1 + c.len);
            chk(ng, !c.dly_n);
            if (c.handshake_input_enable) chk(nc >= dly && nc <= dly + 2, 1);
            else chk(nc, 16 - c.wait_cnt);
            chk(n, 2 + c.len + !c.dly_n + nc + !c.tri_n);
            chk(ncs, (wr ? c.csw : c.csr) ? nc : na + ng + nc);
            chk({bus_16bit, bus_mux}, c.bus_type_field);
            chk(bad, 0);
        end
    endtask : do_acc

    // ************************************************************
    // clock, watchdog and main sequence
    // ************************************************************
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // the tests need about a thousand cycles; this cuts a hang short
    initial begin
        repeat (30000) @(posedge clk);
        mismatches++;
        finish_test();
    end

    initial begin
        nrst = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
        external_access_pin = 1'b1; boot_config_port = 8'h00; req_valid = 1'b0;
        req_write = 1'b0; req_window = 3'h0; pol = 1'b0; dly = 3'h2;
        seed = $urandom(32'hE024);
        bt = 2'($urandom);
        do_reset(1'b1, bt);
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, widx[i], 32'h0);
            chk(rdat, 32'h0);
        end
        do_reset(1'b0, bt);
        apb(1'b0, widx[0], 32'h0);
        chk(rdat, {16'h0, 16'h0600 | {8'h00, bt, 6'h00}});
        cfg[0] = 16'h0600 | {8'h00, bt, 6'h00};
        do_acc(0, 1'b0);
        // idle status after a counted read: state idle, no waits left, read
        apb(1'b0, REG_STAT_IDX, 32'h0);
        chk(rdat, 32'h0);
        chk(rerr, 0);
        apb(1'b1, 16'h0040, $urandom);
        chk(rerr, 1);
        apb(1'b1, REG_STAT_IDX, $urandom);
        chk(rerr, 1);
        for (int r = 0; r < 5; r++) begin
            for (int i = 0; i < 5; i++) begin
                cfg[i] = (r == 0 ? corner[i] : 16'($urandom)) & WIN_WMASK;
                if (r > 0 && $urandom % 4 != 0) cfg[i].act = 1'b1;
                apb(1'b1, widx[i], {16'($urandom), cfg[i]});
                apb(1'b0, widx[i], 32'h0);
                chk(rdat, {16'h0, cfg[i]});
                chk(rerr, 0);
            end
            for (int i = 0; i < 5; i++) do_acc(i, 1'(r));
            repeat (4) do_acc($urandom % 5, 1'($urandom));
        end
        finish_test();
    end
endmodule : ebw_top_tb
